// ===== shared/dls_pkg.sv
/*
  Shared constants for the serial load-mode setup path of a dual 16-bit converter:
  frame layout, command codes, reset values and host clock timing.
  Assumes a 100 MHz system clock on both ends and a host that makes the serial clock.
*/
// Functional notes
// [RL1] Command field 110 selects load-mode setup
// [RL2] Frame bit 1 to B, bit 0 to A
// [RL3] Other frame bits ignored for setup command
// [RL4] Host holds frame sync low during frame
// [RL5] Host uses clock polarity 0, phase 1
// [RL6] Bit 23 first, device shifts MSB first
// [RL7] Byte-wise host keeps sync low between bytes
// [RL8] Device counts only falling serial clock edges
// [RL9] LSB-first host reverses each byte first
// [RL10] Three-wire master shifts out on falling edge
// [RL11] Mode bits reset to 0, strobe-controlled
// [RL12] Mode 1 updates output at 24th fall
// [RL13] Strobe low passes input to output
// [RL14] Transfer only if input written since update
// [RL15] Act after 24 edges, drop partial frames
// [RL16] Sync high clears bit counter
package dls_pkg;
  localparam int FRAME_BITS = 24;
  localparam int DATA_WIDTH = 16;
  localparam int CMD_HI = 21;
  localparam int CMD_LO = 19;
  localparam int ADDR_HI = 18;
  localparam int ADDR_LO = 16;
  localparam int DATA_HI = 15;
  localparam int MODE_B_BIT = 1;
  localparam int MODE_A_BIT = 0;
  localparam logic [2:0] CMD_LOAD_SETUP = 3'h6;
  localparam logic [2:0] CMD_WRITE_INPUT = 3'h0;
  localparam logic [2:0] ADDR_CH_A = 3'h0;
  localparam logic [2:0] ADDR_CH_B = 3'h1;
  localparam logic [2:0] ADDR_ALL = 3'h7;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 60;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 : (SCLK_HALF_NS / CLK_PERIOD_NS);
  localparam int BYTE_GAP_CYCLES = 2 * SCLK_HALF_CYCLES;
endpackage : dls_pkg

// ===== shared/dls_link_if.sv
/*
  Serial link between host and converter: serial clock, data and active-low frame sync.
  Assumes the host drives all three wires; the device only listens.
*/
`timescale 1ns/100ps
interface dls_link_if;
  logic sclk;
  logic din;
  logic sync_n;
  modport host (output sclk, output din, output sync_n);
  modport device (input sclk, input din, input sync_n);
endinterface : dls_link_if

// ===== design/dls_device.sv
/*
  Converter end: synchronises the serial link, assembles 24-bit frames, keeps the per-channel
  load-mode bits and the input and output registers of both channels.
  Assumes the link and the load strobe are asynchronous to CLK_IN and slow enough to be
  oversampled (serial clock half period of at least three system clocks).
*/
`timescale 1ns/100ps
module dls_device #(
  parameter int DATA_W = dls_pkg::DATA_WIDTH
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  dls_link_if.device LINK,
  input wire logic LOAD_OUTPUT_STROBE_N_IN,
  output logic [DATA_W-1:0] DAC_A_OUT,
  output logic [DATA_W-1:0] DAC_B_OUT,
  output logic [1:0] MODE_OUT,
  output logic FRAME_DONE_OUT
);

  localparam int CH_N = 2;

  if (DATA_W < 1 || DATA_W > dls_pkg::DATA_HI + 1) begin : g_bad_width
    $error("DATA_W must lie between 1 and 16");
  end

  // Synchronisers: stage 1 feeds stage 2 only; stage 3 of the clock is for edge finding
  logic sclk_s1_q;
  logic sclk_s2_q;
  logic sclk_s3_q;
  logic din_s1_q;
  logic din_s2_q;
  logic sync_s1_q;
  logic sync_s2_q;
  logic ld_s1_q;
  logic ld_s2_q;
  logic sclk_s1_d;
  logic sclk_s2_d;
  logic sclk_s3_d;
  logic din_s1_d;
  logic din_s2_d;
  logic sync_s1_d;
  logic sync_s2_d;
  logic ld_s1_d;
  logic ld_s2_d;

  always_comb begin
    sclk_s1_d = LINK.sclk;
    sclk_s2_d = sclk_s1_q;
    sclk_s3_d = sclk_s2_q;
    din_s1_d = LINK.din;
    din_s2_d = din_s1_q;
    sync_s1_d = LINK.sync_n;
    sync_s2_d = sync_s1_q;
    ld_s1_d = LOAD_OUTPUT_STROBE_N_IN;
    ld_s2_d = ld_s1_q;
  end

  // Idle levels at reset: clock low, sync and strobe high, so no false edge or transfer
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
      sync_s1_q <= 1'b1;
      sync_s2_q <= 1'b1;
      ld_s1_q <= 1'b1;
      ld_s2_q <= 1'b1;
    end else if (CE_IN) begin
      sclk_s1_q <= sclk_s1_d;
      sclk_s2_q <= sclk_s2_d;
      sclk_s3_q <= sclk_s3_d;
      din_s1_q <= din_s1_d;
      din_s2_q <= din_s2_d;
      sync_s1_q <= sync_s1_d;
      sync_s2_q <= sync_s2_d;
      ld_s1_q <= ld_s1_d;
      ld_s2_q <= ld_s2_d;
    end
  end

  // Frame assembly
  // A frame cut short by sync rising leaves mode and registers untouched
  logic sclk_fall;
  logic [dls_pkg::FRAME_BITS-1:0] shift_q;
  logic [dls_pkg::FRAME_BITS-1:0] shift_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic done;
  logic done_q;

  assign sclk_fall = sclk_s3_q & ~sclk_s2_q; // see [RL8]

  always_comb begin
    shift_d = shift_q;
    cnt_d = cnt_q;
    done = 1'b0;
    if (sync_s2_q) begin
      cnt_d = 5'h00; // see [RL16] see [RL15]
    end else if (sclk_fall && cnt_q < 5'(dls_pkg::FRAME_BITS)) begin
      shift_d = {shift_q[dls_pkg::FRAME_BITS-2:0], din_s2_q}; // see [RL6]
      cnt_d = cnt_q + 5'h01;
      // Edges past the 24th are ignored until sync rises again
      done = (cnt_q == 5'(dls_pkg::FRAME_BITS - 1)); // see [RL15]
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      shift_q <= '0;
      cnt_q <= 5'h00;
      done_q <= 1'b0;
    end else if (CE_IN) begin
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      done_q <= done;
    end
  end

  // Command decode
  logic [2:0] cmd;
  logic [2:0] addr;
  logic is_setup;
  logic is_write;

  assign cmd = shift_d[dls_pkg::CMD_HI:dls_pkg::CMD_LO];
  assign addr = shift_d[dls_pkg::ADDR_HI:dls_pkg::ADDR_LO];
  assign is_setup = done && (cmd == dls_pkg::CMD_LOAD_SETUP); // see [RL1]
  assign is_write = done && (cmd == dls_pkg::CMD_WRITE_INPUT);

  // Load-mode bits
  // The new mode governs later frames, not the setup frame itself
  logic [1:0] mode_q;
  logic [1:0] mode_d;

  always_comb begin
    mode_d = mode_q;
    if (is_setup) begin
      // Only bits 1 and 0 matter here; the rest of the frame is don't-care
      mode_d = {shift_d[dls_pkg::MODE_B_BIT], shift_d[dls_pkg::MODE_A_BIT]}; // see [RL2] see [RL3]
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      mode_q <= dls_pkg::MODE_RESET; // see [RL11]
    end else if (CE_IN) begin
      mode_q <= mode_d;
    end
  end

  // Per-channel input and output registers; each channel owns its output register

  for (genvar ch = 0; ch < CH_N; ch++) begin : g_ch
    logic [DATA_W-1:0] in_q;
    logic [DATA_W-1:0] out_q;
    logic [DATA_W-1:0] in_d;
    logic [DATA_W-1:0] out_d;
    logic pend_q;
    logic pend_d;
    logic hit;
    logic xfer;

    assign hit = is_write && (addr == dls_pkg::ADDR_ALL || addr == 3'(ch));

    always_comb begin
      in_d = in_q;
      out_d = out_q;
      pend_d = pend_q;
      xfer = 1'b0;
      if (hit) begin
        in_d = shift_d[DATA_W-1:0];
        // A write in the same cycle as a transfer goes straight to the output and clears the pending mark
        pend_d = 1'b1;
      end
      // Mode 1 acts as a strobe held low, but only at the end of a frame
      if (pend_d && (!ld_s2_q || (mode_q[ch] && done))) begin // see [RL12] see [RL13] see [RL14]
        xfer = 1'b1;
      end
      if (xfer) begin
        out_d = in_d;
        pend_d = 1'b0;
      end
    end

    always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
        in_q <= '0;
        out_q <= '0;
        pend_q <= 1'b0;
      end else if (CE_IN) begin
        in_q <= in_d;
        out_q <= out_d;
        pend_q <= pend_d;
      end
    end
  end

  assign DAC_A_OUT = g_ch[0].out_q;
  assign DAC_B_OUT = g_ch[1].out_q;
  assign MODE_OUT = mode_q;
  assign FRAME_DONE_OUT = done_q;

endmodule : dls_device

// ===== design/dls_host.sv
/*
  Host end: serial master that sends one 24-bit frame per start request, whole or as
  three bytes, with the serial clock derived from CLK_IN by a divider.
  Assumes START_IN comes from logic on CLK_IN and is given only while BUSY_OUT is low.
*/
`timescale 1ns/100ps
module dls_host #(
  parameter int HALF_CYCLES = dls_pkg::SCLK_HALF_CYCLES,
  parameter int GAP_CYCLES = dls_pkg::BYTE_GAP_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic START_IN,
  input wire logic [dls_pkg::FRAME_BITS-1:0] FRAME_IN,
  input wire logic BYTE_WISE_IN,
  dls_link_if.host LINK,
  output logic BUSY_OUT,
  output logic DONE_OUT
);

  if (HALF_CYCLES < 1 || HALF_CYCLES > 255 || GAP_CYCLES < 1 || GAP_CYCLES > 255) begin : g_bad_time
    $error("HALF_CYCLES and GAP_CYCLES must lie between 1 and 255");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_HIGH, ST_LOW, ST_GAP, ST_TRAIL} dls_state_t;

  dls_state_t st_q;
  dls_state_t st_d;
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic [4:0] bit_q;
  logic [4:0] bit_d;
  logic [dls_pkg::FRAME_BITS-1:0] sh_q;
  logic [dls_pkg::FRAME_BITS-1:0] sh_d;
  logic byte_q;
  logic byte_d;
  logic sclk_q;
  logic sclk_d;
  logic din_q;
  logic din_d;
  logic sync_n_q;
  logic sync_n_d;
  logic done_q;
  logic done_d;
  logic half_up;

  assign half_up = (div_q == 8'(HALF_CYCLES - 1));

  always_comb begin
    st_d = st_q;
    div_d = div_q + 8'h01;
    bit_d = bit_q;
    sh_d = sh_q;
    byte_d = byte_q;
    sclk_d = sclk_q;
    din_d = din_q;
    sync_n_d = sync_n_q;
    done_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        div_d = 8'h00;
        if (START_IN) begin
          sh_d = FRAME_IN;
          byte_d = BYTE_WISE_IN;
          bit_d = 5'h00;
          sync_n_d = 1'b0; // see [RL4]
          st_d = ST_LEAD;
        end
      end
      ST_LEAD, ST_GAP: begin
        if ((st_q == ST_LEAD && half_up) || (st_q == ST_GAP && div_q == 8'(GAP_CYCLES - 1))) begin
          div_d = 8'h00;
          // Data changes on the rising edge so it is steady at the falling edge
          sclk_d = 1'b1; // see [RL5]
          din_d = sh_q[dls_pkg::FRAME_BITS-1]; // see [RL6]
          st_d = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (half_up) begin
          div_d = 8'h00;
          sclk_d = 1'b0;
          sh_d = {sh_q[dls_pkg::FRAME_BITS-2:0], 1'b0};
          bit_d = bit_q + 5'h01;
          st_d = ST_LOW;
        end
      end
      ST_LOW: begin
        if (half_up) begin
          div_d = 8'h00;
          if (bit_q == 5'(dls_pkg::FRAME_BITS)) begin
            sync_n_d = 1'b1;
            st_d = ST_TRAIL;
          end else if (byte_q && bit_q[2:0] == 3'h0) begin
            // Sync stays low across the pause between bytes
            st_d = ST_GAP; // see [RL7]
          end else begin
            sclk_d = 1'b1;
            din_d = sh_q[dls_pkg::FRAME_BITS-1];
            st_d = ST_HIGH;
          end
        end
      end
      ST_TRAIL: begin
        // Sync held high one half period so the device sees the frame end
        if (half_up) begin
          div_d = 8'h00;
          done_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
        sclk_d = 1'b0;
        sync_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      st_q <= ST_IDLE;
      div_q <= 8'h00;
      bit_q <= 5'h00;
      sh_q <= '0;
      byte_q <= 1'b0;
      sclk_q <= 1'b0;
      din_q <= 1'b0;
      sync_n_q <= 1'b1;
      done_q <= 1'b0;
    end else if (CE_IN) begin
      st_q <= st_d;
      div_q <= div_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      byte_q <= byte_d;
      sclk_q <= sclk_d;
      din_q <= din_d;
      sync_n_q <= sync_n_d;
      done_q <= done_d;
    end
  end

  logic busy_q;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      busy_q <= 1'b0;
    end else if (CE_IN) begin
      busy_q <= (st_d != ST_IDLE);
    end
  end

  assign LINK.sclk = sclk_q;
  assign LINK.din = din_q;
  assign LINK.sync_n = sync_n_q;
  assign BUSY_OUT = busy_q;
  assign DONE_OUT = done_q;

endmodule : dls_host

// ===== verif/dls_link_props.sv
/*
  Checker for the serial link wires between host end and converter end.
  Assumes registered host outputs sampled on CLK_IN and the default half period of 6 cycles.
*/
`timescale 1ns/100ps
module dls_link_props (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic sclk_in,
  input wire logic din_in,
  input wire logic sync_n_in
);
  logic sclk_q;
  logic sclk_d;
  logic [4:0] fall_cnt_q;
  logic [4:0] fall_cnt_d;
  // Counts falls seen inside a frame, so framing is judged on the wire alone
  always_comb begin
    sclk_d = sclk_in;
    fall_cnt_d = fall_cnt_q;
    if (sync_n_in) begin
      fall_cnt_d = 5'h00;
    end else if (sclk_q && !sclk_in) begin
      fall_cnt_d = fall_cnt_q + 5'h01;
    end
  end
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      sclk_q <= 1'b0;
      fall_cnt_q <= 5'h00;
    end else begin
      sclk_q <= sclk_d;
      fall_cnt_q <= fall_cnt_d;
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  a_whole_frame_count: assert property ($rose(sync_n_in) |-> fall_cnt_q == 5'h18)
    else $error("frame sync rose before a whole frame");
  a_fall_count_cap: assert property (fall_cnt_q <= 5'h18)
    else $error("more falls than one frame holds");
  a_idle_clock_low: assert property (sync_n_in |-> !sclk_in)
    else $error("serial clock not low outside a frame");
  a_data_stable_fall: assert property ($fell(sclk_in) |-> $stable(din_in))
    else $error("data moved at a falling clock edge");
  a_sync_lead_in: assert property ($fell(sync_n_in) |-> !sclk_in [*6] ##1 sclk_in)
    else $error("first clock rise not one half period after sync");
  a_high_half: assert property ($rose(sclk_in) |-> sclk_in [*6] ##1 !sclk_in)
    else $error("clock high half period wrong");
  a_low_half: assert property ($fell(sclk_in) |-> !sclk_in [*6])
    else $error("clock low half period too short");
  a_sync_gap: assert property ($rose(sync_n_in) |-> sync_n_in [*3])
    else $error("frame sync high too briefly");
  a_reset_idle: assert property ($fell(RST_IN) |-> sync_n_in && !sclk_in)
    else $error("link not idle after reset");
endmodule : dls_link_props

// ===== verif/test_dual_dac_serial_load_mode_setup.sv
/*
  Testbench: host end drives the converter end over the link; a model with integers checks results.
  Assumes default host timing; a host-only reset cuts a frame short on purpose.
*/
`timescale 1ns/100ps
module test_dual_dac_serial_load_mode_setup;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic abort = 1'b0;
  logic start = 1'b0;
  logic [23:0] frame = 24'h000000;
  logic byte_wise = 1'b0;
  logic strobe_n = 1'b1;
  logic [15:0] dac_a;
  logic [15:0] dac_b;
  logic [1:0] mode;
  logic frame_done;
  logic busy;
  logic done;
  int mismatches = 0;
  int checks = 0;
  int frames_m = 0;
  int frames_seen = 0;
  int cycles = 0;
  int mode_m = 0;
  int in_m[2] = '{0, 0};
  int out_m[2] = '{0, 0};
  bit pend_m[2] = '{0, 0};
  dls_link_if link ();
  always #5 clk = ~clk;
  dls_host dls_host_i (.CLK_IN(clk), .RST_IN(rst | abort), .CE_IN(1'b1), .START_IN(start), .FRAME_IN(frame),
    .BYTE_WISE_IN(byte_wise), .LINK(link.host), .BUSY_OUT(busy), .DONE_OUT(done));
  dls_device dls_device_i (.CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .LINK(link.device),
    .LOAD_OUTPUT_STROBE_N_IN(strobe_n), .DAC_A_OUT(dac_a), .DAC_B_OUT(dac_b), .MODE_OUT(mode),
    .FRAME_DONE_OUT(frame_done));
  dls_link_props dls_link_props_i (.CLK_IN(clk), .RST_IN(rst | abort), .sclk_in(link.sclk), .din_in(link.din),
    .sync_n_in(link.sync_n));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  // Ceiling well above the roughly 5500 cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end
  // Frame-done pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    if (frame_done === 1'b1) frames_seen++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic compare();
    check({14'h0000, mode}, mode_m[15:0]);
    check(dac_a, out_m[0][15:0]);
    check(dac_b, out_m[1][15:0]);
    check(frames_seen[15:0], frames_m[15:0]);
  endtask : compare
  task automatic apply();
    for (int c = 0; c < 2; c++) begin
      if (pend_m[c] && (mode_m[c] || !strobe_n)) begin
        out_m[c] = in_m[c];
        pend_m[c] = 1'b0;
      end
    end
  endtask : apply
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // A cut above zero resets the host that many cycles into the frame
  task automatic send(input logic [23:0] f, input logic bw, input int cut);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      step(1);
      n++;
    end
    if (n >= 1000) mismatches++;
    frame = f;
    byte_wise = bw;
    start = 1'b1;
    step(1);
    start = 1'b0;
    if (cut > 0) begin
      step(cut);
      abort = 1'b1;
      step(2);
      abort = 1'b0;
    end else begin
      n = 0;
      while (done !== 1'b1 && n < 2000) begin
        step(1);
        n++;
      end
      if (n >= 2000) mismatches++;
      frames_m++;
      for (int c = 0; c < 2; c++) begin
        if (f[21:19] == 3'h0 && (f[18:16] == c || f[18:16] == 3'h7)) begin
          in_m[c] = f[15:0];
          pend_m[c] = 1'b1;
        end
      end
      // The setup frame ends under the old mode; its new mode serves later frames
      apply();
      if (f[21:19] == 3'h6) mode_m = f[1:0];
    end
    step(2);
    compare();
  endtask : send
  task automatic pulse_strobe();
    strobe_n = 1'b0;
    step(6);
    apply();
    compare();
    strobe_n = 1'b1;
    step(6);
  endtask : pulse_strobe
  initial begin
    logic [23:0] f;
    void'($urandom(49));
    step(3);
    rst = 1'b0;
    step(4);
    compare();
    for (int i = 0; i < 8; i++) begin
      f = 24'($urandom);
      f[21:19] = 3'h6;
      f[1:0] = i[1:0];
      send(f, i[2], 0);
    end
    for (int c = 1; c < 8; c++) begin
      f = 24'($urandom);
      f[21:19] = c[2:0];
      if (c != 6) send(f, c[0], 0);
    end
    send(24'($urandom) & 24'hC7FFFE | 24'h300002, 1'b0, 0);
    send({2'h0, 3'h0, 3'h7, 16'($urandom)}, 1'b1, 0);
    pulse_strobe();
    pulse_strobe();
    send(24'h300001, 1'b0, 100);
    send({8'h01, 16'($urandom)}, 1'b1, 0);
    conclude();
  end
endmodule : test_dual_dac_serial_load_mode_setup
